/* hdl/pgm_pkg.sv */
// Constants, register map and carrier types for the power-good monitor
// Assumes a 50 MHz core clock and a classic Wishbone slave port
// Summary of operation
// - LDO leaving range sets rail and summary flags
// - Power-good drop sets flag; state bit live
// - Sync clock change sets flag with status
// - Measurement done sets flag, no status
// - Undervoltage resets everything, no flags
// - Supply rise sets reset flag unless masked
// - Software reset restarts, sets reset flag
// - Polarity inverts only the external pin
// - Per-rail inclusion; disabled rails excluded
// - Thermal warning optionally joins power-good
// - Power-good needs every selected source valid
// - Window bit adds overvoltage check
// - Pin polarity and open-drain selectable
// - Mode bit: zero gated, one continuous
// - Gated mode holds state 800 us
// - Gated fault latches and stops monitoring
// - Continuous mode follows regulation after enable
// - Fault bits latch until written one
// - Continuous mode: rail transition forces power-good inactive
// - Fault gating option holds power-good low
// - 20 us peak current sets limit flag
// - Each buck has 3-bit current limit
// - Interrupt pin low while unmasked flag pending
package pgm_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int HOLD_US = 800;
    localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
    localparam int ILIM_US = 20;
    localparam int ILIM_CYC = ILIM_US * (CLK_HZ / 1_000_000);

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_MASKS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PG_CTRL = 8'h0c;
    localparam logic [7:0] REG_FAULT = 8'h10;
    localparam logic [7:0] REG_ILIM = 8'h14;
    localparam logic [7:0] REG_RESET = 8'h18;

    // Flag / mask bit positions
    localparam int F_LDO0 = 0;
    localparam int F_LDO1 = 1;
    localparam int F_LDO_SUM = 2;
    localparam int F_PG_DROP = 3;
    localparam int F_SYNC = 4;
    localparam int F_MEAS = 5;
    localparam int F_RESET = 6;
    localparam int F_ILIM0 = 7;
    localparam int F_ILIM1 = 8;
    localparam int NFLAG = 9;

    // Power-good control field positions
    localparam int C_BUCK_EN = 0;   // 2 bits
    localparam int C_LDO_EN = 2;    // 2 bits
    localparam int C_TWARN = 4;
    localparam int C_WIN = 5;       // 4 bits: buck0, buck1, ldo0, ldo1
    localparam int C_POL = 9;
    localparam int C_OD = 10;
    localparam int C_MODE = 11;
    localparam int C_FGATE = 12;
    localparam int CTRL_W = 13;

    // Reset values; mode and reset mask stand for programmed defaults
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h000f;
    localparam logic [NFLAG-1:0] MASK_RST = 9'h000;
    localparam logic [5:0] ILIM_RST = 6'h1b;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [3:0] enabled;   // buck0, buck1, ldo0, ldo1 regulator on
        logic [3:0] under_ok;  // above undervoltage threshold
        logic [3:0] over_ok;   // below overvoltage threshold
        logic [3:0] moving;    // ramping between targets
        logic [3:0] change;    // enable or voltage change request pulse
    } pgm_rail_t;

    typedef struct packed {
        logic thermal_warn_status;
        logic ovp_pending;
        logic tsd_pending;
        logic sync_clk_present;
        logic meas_done;
        logic [1:0] buck_in_ilim;
    } pgm_event_t;

    typedef enum {ST_LOAD, ST_HOLD, ST_RUN} pgm_state_t;
endpackage

/* hdl/pgm_top.sv */
// Power-good aggregation, rail fault latches and interrupt flags
// Assumes synchronous analog indications and a Wishbone classic master
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module pgm_top (
    input wire logic core_clk,                 // 50 MHz clock
    input wire logic rst_n,                    // Undervoltage reset, low
    input wire logic otp_done,                 // Configuration load finished
    input wire pgm_pkg::pgm_rail_t rails,      // Rail monitor inputs
    input wire pgm_pkg::pgm_event_t events,    // Other event inputs
    input wire logic [7:0] wb_adr_i,           // Wishbone address
    input wire logic [31:0] wb_dat_i,          // Wishbone write data
    input wire logic [3:0] wb_sel_i,           // Byte selects
    input wire logic wb_we_i,                  // Write enable
    input wire logic wb_cyc_i,                 // Cycle
    input wire logic wb_stb_i,                 // Strobe
    output logic [31:0] wb_dat_o,              // Read data
    output logic wb_ack_o,                     // Acknowledge
    output logic power_good_pin_o,             // Pin output level
    output logic power_good_pin_oe,            // Pin output enable
    output logic interrupt_pin_n,              // Interrupt, active low
    output logic sw_reset_o,                   // Regulator shutdown pulse
    output logic [5:0] buck_peak_current_limit // Two 3-bit limit fields
);
    import pgm_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [NFLAG-1:0] flag_q;
    logic [NFLAG-1:0] mask_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [3:0] rail_fault_latches_q;
    logic [5:0] ilim_q;
    logic sw_rst_q;
    logic sw_rst_seen_q;
    logic pg_q;
    logic pg_prev_q;
    logic sync_prev_q;
    logic [3:0] ldo_prev_q;
    logic [15:0] hold_q;
    logic [9:0] ilim_cnt0_q;
    logic [9:0] ilim_cnt1_q;
    pgm_state_t state_q;

    // Bus write and acknowledge strobes
    logic wr;
    logic rd_ack;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    function automatic logic [31:0] w1c(input logic [7:0] a);
        w1c = (wr && wb_adr_i == a) ? wb_dat_i : 32'h0000_0000;
    endfunction

    // Write-one-clear words; a function result cannot be sliced directly
    logic [31:0] clr_flags;
    logic [31:0] clr_fault;
    assign clr_flags = w1c(REG_FLAGS);
    assign clr_fault = w1c(REG_FAULT);

    function automatic logic cnt_hit(input logic [9:0] c, input logic on);
        cnt_hit = on && (c == 10'(ILIM_CYC - 1));
    endfunction

    // ************************************************************
    // Rail evaluation
    // ************************************************************
    logic [3:0] rail_in;
    logic [3:0] rail_ok;
    logic [3:0] rail_bad;
    logic src_ok;
    logic moving;
    always_comb
    begin
        rail_in = {ctrl_q[C_LDO_EN +: 2], ctrl_q[C_BUCK_EN +: 2]} & rails.enabled;
        rail_ok = rails.under_ok & (rails.over_ok | ~ctrl_q[C_WIN +: 4]);
        rail_bad = rail_in & ~rail_ok;
        moving = |(rail_in & rails.moving);
        src_ok = ~(|rail_bad)
            & ~(ctrl_q[C_TWARN] & events.thermal_warn_status)
            & ~events.ovp_pending & ~events.tsd_pending;
    end

    // ************************************************************
    // Power-good state machine
    // ************************************************************
    logic any_change;
    assign any_change = |rails.change;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_LOAD;
            pg_q <= 1'b0;
            hold_q <= 16'h0000;
        end
        else if (sw_rst_q)
        begin
            state_q <= ST_LOAD;
            pg_q <= 1'b0;
            hold_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ST_LOAD:
                    if (otp_done)
                    begin
                        pg_q <= 1'b1;
                        state_q <= ST_RUN;
                    end
                ST_HOLD:
                begin
                    // Timer restarts on every new request
                    if (any_change)
                        hold_q <= 16'(HOLD_CYC - 1);
                    else if (hold_q == 16'h0000)
                        state_q <= ST_RUN;
                    else
                        hold_q <= hold_q - 16'h0001;
                end
                ST_RUN:
                    if (!ctrl_q[C_MODE])
                    begin
                        // Gated: latched faults freeze monitoring
                        if (any_change)
                        begin
                            hold_q <= 16'(HOLD_CYC - 1);
                            state_q <= ST_HOLD;
                        end
                        else if (!src_ok || (|rail_fault_latches_q))
                            pg_q <= 1'b0;
                        else
                            pg_q <= 1'b1;
                    end
                    else
                    begin
                        // Continuous: follow status, transitions force low
                        pg_q <= src_ok & ~moving & ~any_change
                            & ~(ctrl_q[C_FGATE] & (|rail_fault_latches_q));
                    end
                default:
                    state_q <= ST_LOAD;
            endcase
        end
    end

    // ************************************************************
    // Rail fault latches
    // ************************************************************
    logic monitoring;
    assign monitoring = (state_q == ST_RUN) && !any_change;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rail_fault_latches_q <= 4'h0;
        else if (sw_rst_q)
            rail_fault_latches_q <= 4'h0;
        else
            // Set wins over a simultaneous clear
            rail_fault_latches_q <= (rail_fault_latches_q & ~clr_fault[3:0])
                | (monitoring ? rail_bad : 4'h0);
    end

    // ************************************************************
    // Current-limit persistence counters
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ilim_cnt0_q <= 10'h000;
            ilim_cnt1_q <= 10'h000;
        end
        else
        begin
            // Saturate one past the hit count so one episode raises one flag
            if (!events.buck_in_ilim[0])
                ilim_cnt0_q <= 10'h000;
            else if (ilim_cnt0_q != 10'(ILIM_CYC))
                ilim_cnt0_q <= ilim_cnt0_q + 10'h001;
            if (!events.buck_in_ilim[1])
                ilim_cnt1_q <= 10'h000;
            else if (ilim_cnt1_q != 10'(ILIM_CYC))
                ilim_cnt1_q <= ilim_cnt1_q + 10'h001;
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    logic [NFLAG-1:0] set;
    logic [1:0] ldo_fall;
    always_comb
    begin
        set = '0;
        ldo_fall = ldo_prev_q[3:2] & ~rail_ok[3:2] & rails.enabled[3:2];
        set[F_LDO0] = ldo_fall[0] & ~mask_q[F_LDO0];
        set[F_LDO1] = ldo_fall[1] & ~mask_q[F_LDO1];
        set[F_LDO_SUM] = set[F_LDO0] | set[F_LDO1];
        set[F_PG_DROP] = pg_prev_q & ~pg_q;
        set[F_SYNC] = sync_prev_q ^ events.sync_clk_present;
        set[F_MEAS] = events.meas_done;
        set[F_RESET] = sw_rst_seen_q & otp_done;
        set[F_ILIM0] = cnt_hit(ilim_cnt0_q, events.buck_in_ilim[0]);
        set[F_ILIM1] = cnt_hit(ilim_cnt1_q, events.buck_in_ilim[1]);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_q <= '0;
            pg_prev_q <= 1'b0;
            sync_prev_q <= 1'b0;
            ldo_prev_q <= 4'h0;
        end
        else
        begin
            // Set wins over a simultaneous write-one clear
            flag_q <= (flag_q & ~clr_flags[NFLAG-1:0]) | set;
            pg_prev_q <= pg_q;
            sync_prev_q <= events.sync_clk_present;
            ldo_prev_q <= rail_ok & rails.enabled;
        end
    end

    // Reset flag pending until the startup after power or software reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sw_rst_seen_q <= ~MASK_RST[F_RESET];
        else if (sw_rst_q)
            sw_rst_seen_q <= ~MASK_RST[F_RESET];
        else if (otp_done)
            sw_rst_seen_q <= 1'b0;
    end

    // ************************************************************
    // Configuration registers and software reset
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_q <= MASK_RST;
            ctrl_q <= CTRL_RST;
            ilim_q <= ILIM_RST;
            sw_rst_q <= 1'b0;
        end
        else if (sw_rst_q)
        begin
            mask_q <= MASK_RST;
            ctrl_q <= CTRL_RST;
            ilim_q <= ILIM_RST;
            sw_rst_q <= 1'b0;
        end
        else
        begin
            if (wr && wb_adr_i == REG_MASKS)
                mask_q <= wb_dat_i[NFLAG-1:0];
            if (wr && wb_adr_i == REG_PG_CTRL)
                ctrl_q <= wb_dat_i[CTRL_W-1:0];
            if (wr && wb_adr_i == REG_ILIM)
                ilim_q <= wb_dat_i[5:0];
            sw_rst_q <= wr && wb_adr_i == REG_RESET && wb_dat_i[0];
        end
    end

    // ************************************************************
    // Wishbone read path, single-wait ack
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= rd_ack;
            case (wb_adr_i)
                REG_FLAGS: wb_dat_o <= 32'(flag_q);
                REG_MASKS: wb_dat_o <= 32'(mask_q);
                REG_STATUS: wb_dat_o <= 32'({events.buck_in_ilim, events.thermal_warn_status,
                    events.sync_clk_present, pg_q, rail_ok[3:2]});
                REG_PG_CTRL: wb_dat_o <= 32'(ctrl_q);
                REG_FAULT: wb_dat_o <= 32'(rail_fault_latches_q);
                REG_ILIM: wb_dat_o <= 32'(ilim_q);
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Pins
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_good_pin_o <= 1'b0;
            power_good_pin_oe <= 1'b1;
            interrupt_pin_n <= 1'b1;
            sw_reset_o <= 1'b0;
            buck_peak_current_limit <= ILIM_RST;
        end
        else
        begin
            // Polarity touches the pin only, never pg_q or its flag
            power_good_pin_o <= pg_q ^ ctrl_q[C_POL];
            power_good_pin_oe <= ~ctrl_q[C_OD] | ~(pg_q ^ ctrl_q[C_POL]);
            interrupt_pin_n <= ~(|(flag_q & ~mask_q));
            sw_reset_o <= sw_rst_q;
            buck_peak_current_limit <= ilim_q;
        end
    end
endmodule

/* tb/pgm_host.sv */
// Host model: Wishbone classic master issuing single register accesses
// Assumes the caller enters xfer right after a rising clock edge
`timescale 1ns/1ps
module pgm_host (
    input wire logic core_clk, // Clock
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Acknowledge
    output logic [7:0] wb_adr_i, // Address
    output logic [31:0] wb_dat_i, // Write data
    output logic [3:0] wb_sel_i, // Byte selects
    output logic wb_we_i, // Write enable
    output logic wb_cyc_i, // Cycle
    output logic wb_stb_i // Strobe
);
    // Idle bus from time zero
    initial
    begin
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
    end

    // One access; request held until ack is sampled high
    // No local limit: only the bench watchdog may end a wait
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] d);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= wd;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_dat_i <= ~wd; // Stale data is not left on the bus
        @(posedge core_clk);
    endtask
endmodule

/* tb/pgm_top_assertions.sv */
// Checker for bus handshake, pins and reset pulse of the monitor
// Assumes it is bound to pgm_top and sees only its ports
`timescale 1ns/1ps
module pgm_assertions (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic [7:0] wb_adr_i, // Address
    input wire logic wb_we_i, // Write enable
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Acknowledge
    input wire logic power_good_pin_o, // Pin level
    input wire logic power_good_pin_oe, // Pin enable
    input wire logic interrupt_pin_n, // Interrupt
    input wire logic sw_reset_o, // Shutdown pulse
    input wire logic [5:0] buck_peak_current_limit // Limits
);
    import pgm_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Write requests; flag clears and configuration changes only follow shortly after one
    logic wr_any;
    logic wr_rst;
    assign wr_any = wb_cyc_i && wb_stb_i && wb_we_i;
    assign wr_rst = wr_any && (wb_adr_i == REG_RESET);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_recent_wr;
        $past(wr_any, 1) || $past(wr_any, 2) || $past(wr_any, 3) || $past(wr_any, 4);
    endsequence

    // ******************************
    // Properties
    // ******************************
    a_ack_answers: assert property (s_req |=> s_ack_pulse)
        else $error("ack missing or longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_int_release: assert property ($rose(interrupt_pin_n) |-> s_recent_wr)
        else $error("interrupt released without a host write");
    a_srst_single: assert property (sw_reset_o |=> !sw_reset_o)
        else $error("shutdown pulse too long");
    a_srst_cause: assert property ($rose(sw_reset_o) |-> $past(wr_rst) || $past(wr_rst, 2))
        else $error("shutdown pulse without reset write");
    a_srst_defaults: assert property (sw_reset_o |-> ##[0:3] buck_peak_current_limit == ILIM_RST)
        else $error("limits not back to default after reset");
    a_od_release: assert property (!power_good_pin_oe |-> power_good_pin_o)
        else $error("pin released while driving low");
    a_limit_by_write: assert property (!$stable(buck_peak_current_limit) |-> s_recent_wr)
        else $error("limit field changed without a write");
endmodule

bind pgm_top pgm_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .power_good_pin_o(power_good_pin_o), .power_good_pin_oe(power_good_pin_oe),
    .interrupt_pin_n(interrupt_pin_n), .sw_reset_o(sw_reset_o),
    .buck_peak_current_limit(buck_peak_current_limit));

/* tb/tb_top.sv */
// Testbench for the power-good monitor with a behavioural model
// Assumes the host model in pgm_host and the bound checker
`timescale 1ns/1ps
module tb_top;
    import pgm_pkg::*;
    logic core_clk, rst_n, otp_done, ack, we, cyc, stb, pin, oe, int_n, srst;
    logic [7:0] adr;
    logic [31:0] wd, rdat, d;
    logic [3:0] sel;
    logic [5:0] lim;
    pgm_rail_t rails, r;
    pgm_event_t events, e;
    int n_mismatch, check_count, saw_rst, ctrl;
    logic pg;

    pgm_host host (.core_clk(core_clk), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb));
    pgm_top dut (.core_clk(core_clk), .rst_n(rst_n), .otp_done(otp_done), .rails(rails),
        .events(events), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .power_good_pin_o(pin), .power_good_pin_oe(oe), .interrupt_pin_n(int_n),
        .sw_reset_o(srst), .buck_peak_current_limit(lim));

    // Clock; shutdown pulses are counted as they pass
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (srst === 1'b1) saw_rst++;

    // ******************************
    // Helpers and model
    // ******************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        host.xfer(a, 1'b1, v, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        host.xfer(a, 1'b0, 32'h0, d);
        chk(d & m, x);
    endtask
    task automatic drive(input int ticks);
        rails <= r;
        events <= e;
        tick(ticks);
    endtask
    // Power-good when every selected, enabled source is valid
    function automatic logic pg_model(input int c, input pgm_rail_t q, input pgm_event_t v);
        logic ok;
        ok = !v.ovp_pending && !v.tsd_pending;
        if (c[C_TWARN] && v.thermal_warn_status) ok = 1'b0;
        for (int i = 0; i < 4; i++)
            if (c[i] && q.enabled[i] && (!q.under_ok[i] || q.moving[i]
                || (c[C_WIN + i] && !q.over_ok[i]))) ok = 1'b0;
        return ok;
    endfunction
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog longer than the gated hold waits plus the rest
    initial
    begin
        tick(90000);
        n_mismatch++;
        give_verdict();
    end

    // ******************************
    // Main sequence
    // ******************************
    initial
    begin
        rst_n = 1'b0;
        otp_done = 1'b0;
        r = '0;
        r.enabled = 4'hf;
        r.under_ok = 4'hf;
        r.over_ok = 4'hf;
        e = '0;
        rails = r;
        events = e;
        void'($urandom(30038));
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        otp_done <= 1'b1;
        tick(4);
        rc(REG_PG_CTRL, 32'hffff, 32'h000f);
        rc(REG_MASKS, 32'h1ff, 32'h0);
        chk(lim, 6'h1b);
        rc(REG_FLAGS, 32'h1ff, 32'h40);
        chk(int_n, 1'b0);
        wr(REG_FLAGS, 32'h1ff);
        tick(2);
        chk(int_n, 1'b1);
        // Gated hold restarts on a second change request
        r.change = 4'h1;
        drive(1);
        r.change = 4'h0;
        r.under_ok[0] = 1'b0;
        drive(20000);
        r.change = 4'h2;
        drive(1);
        r.change = 4'h0;
        drive(HOLD_CYC - 500);
        chk(pin, 1'b1);
        tick(1000);
        chk(pin, 1'b0);
        rc(REG_FAULT, 32'hf, 32'h1);
        r.under_ok[0] = 1'b1;
        drive(4);
        chk(pin, 1'b0);
        wr(REG_FAULT, 32'h1);
        rc(REG_FAULT, 32'hf, 32'h0);
        // Continuous mode against the model, random configurations
        for (int k = 0; k < 24; k++)
        begin
            ctrl = ($urandom & 32'h7ff) | 32'h800;
            wr(REG_PG_CTRL, ctrl);
            r = pgm_rail_t'($urandom);
            r.change = 4'h0;
            r.under_ok |= 4'($urandom);
            e = pgm_event_t'($urandom & 32'h40);
            e.ovp_pending = ($urandom % 6 == 0);
            e.tsd_pending = ($urandom % 6 == 0);
            drive(4);
            pg = pg_model(ctrl, r, e);
            rc(REG_STATUS, 32'h4, {29'h0, pg, 2'h0});
            chk(pin, pg ^ ctrl[C_POL]);
            chk(oe, !(ctrl[C_OD] && (pg ^ ctrl[C_POL])));
        end
        // LDO0 drop: rail and summary flags, fault latch, fault gating
        wr(REG_PG_CTRL, 32'h80c);
        r = '0;
        r.enabled = 4'hf;
        r.under_ok = 4'hf;
        r.over_ok = 4'hf;
        e = '0;
        drive(4);
        wr(REG_FAULT, 32'hf);
        wr(REG_FLAGS, 32'h1ff);
        r.under_ok[2] = 1'b0;
        drive(4);
        rc(REG_FLAGS, 32'h1ff, 32'h0d);
        chk(int_n, 1'b0);
        rc(REG_FAULT, 32'hf, 32'h4);
        r.under_ok[2] = 1'b1;
        drive(4);
        chk(pin, 1'b1);
        wr(REG_PG_CTRL, 32'h180c);
        tick(3);
        chk(pin, 1'b0);
        wr(REG_FAULT, 32'h4);
        tick(3);
        chk(pin, 1'b1);
        // Masked measurement flag keeps the pin quiet
        wr(REG_FLAGS, 32'h1ff);
        wr(REG_MASKS, 32'h20);
        e.meas_done = 1'b1;
        drive(1);
        e.meas_done = 1'b0;
        drive(3);
        rc(REG_FLAGS, 32'h1ff, 32'h20);
        chk(int_n, 1'b1);
        wr(REG_MASKS, 32'h0);
        tick(3);
        chk(int_n, 1'b0);
        // Sync clock appears and disappears
        wr(REG_FLAGS, 32'h1ff);
        e.sync_clk_present = 1'b1;
        drive(4);
        rc(REG_FLAGS, 32'h1ff, 32'h10);
        rc(REG_STATUS, 32'h8, 32'h8);
        chk(pin, 1'b1);
        wr(REG_FLAGS, 32'h10);
        e.sync_clk_present = 1'b0;
        drive(4);
        rc(REG_FLAGS, 32'h1ff, 32'h10);
        // Peak current regulation held for the limit time
        wr(REG_FLAGS, 32'h1ff);
        e.buck_in_ilim = 2'b01;
        drive(ILIM_CYC - 60);
        rc(REG_FLAGS, 32'h80, 32'h0);
        tick(100);
        rc(REG_FLAGS, 32'h80, 32'h80);
        rc(REG_STATUS, 32'h20, 32'h20);
        e = '0;
        drive(2);
        ctrl = $urandom & 32'h3f;
        wr(REG_ILIM, ctrl);
        rc(REG_ILIM, 32'h3f, ctrl);
        chk(lim, ctrl[5:0]);
        // Software reset, then supply loss with a flag pending
        wr(REG_FLAGS, 32'h1ff);
        wr(REG_RESET, 32'h1);
        tick(3);
        chk(saw_rst, 1);
        rc(REG_PG_CTRL, 32'hffff, 32'h000f);
        otp_done <= 1'b0;
        tick(2);
        otp_done <= 1'b1;
        tick(3);
        rc(REG_FLAGS, 32'h40, 32'h40);
        rst_n <= 1'b0;
        tick(2);
        chk(int_n, 1'b1);
        rst_n <= 1'b1;
        tick(4);
        rc(REG_FLAGS, 32'h1ff, 32'h40);
        give_verdict();
    end
endmodule
